// ### rtl/cis_pkg.sv
// Constants for the charger input supervisor
// ==============================================================
// Contract
// - Over-voltage stops charging, threshold picked by select
// - Restart after over-voltage only below 6.0V
// - USB mode input limit 100mA or 450mA
// - AC mode input limit 2A
// - Disable below 3.5V, restart 500mV above
// - Cut charge current when rail sags 200mV
// - AC mode when select pin above 1.2V
// - AC mode, level pin low divides current by 5
// - USB 90/450mA, precondition 45mA or one tenth
// - Connect event interrupts when both enables set
// - Disconnect event interrupts when both enables set
// - Input valid between under and over thresholds
// - Event flag reads 1 once raised, read clears
// - AC pin level readable at all times
// - Power source: input, battery, or both
// - Interrupt low until cleared and status read
package cis_pkg;
    // ==========================================================
    // Register map, byte addresses of 32-bit words
    localparam logic [7:0] CIS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CIS_ADDR_STATUS = 8'h04;
    localparam logic [7:0] CIS_ADDR_EVENT = 8'h08;
    localparam logic [7:0] CIS_ADDR_MASK = 8'h0C;
    localparam logic [7:0] CIS_ADDR_RAIL_REF = 8'h10;
    // ==========================================================
    // Control field positions
    localparam int CIS_CTRL_OVP_LSB = 0;
    localparam int CIS_CTRL_IRQ_EN = 2;
    localparam int CIS_CTRL_CON_EN = 3;
    localparam int CIS_CTRL_DIS_EN = 4;
    // Status field positions
    localparam int CIS_ST_VALID = 0;
    localparam int CIS_ST_AC = 1;
    localparam int CIS_ST_OVP = 2;
    localparam int CIS_ST_UVLO = 3;
    localparam int CIS_ST_FOLD = 4;
    // Event and mask field positions
    localparam int CIS_EV_FLAG = 0;
    localparam int CIS_EV_CON = 1;
    localparam int CIS_EV_DIS = 2;
    // ==========================================================
    // Reset values
    localparam logic [4:0] CIS_CTRL_RST = 5'h00;
    localparam logic [2:0] CIS_MASK_RST = 3'h7;
    localparam logic [15:0] CIS_RAIL_REF_RST = 16'h1130;
    // ==========================================================
    // Voltages in mV
    localparam logic [15:0] CIS_OVP_6V6 = 16'h19C8;
    localparam logic [15:0] CIS_OVP_7V0 = 16'h1B58;
    localparam logic [15:0] CIS_OVP_7V5 = 16'h1D4C;
    localparam logic [15:0] CIS_OVP_8V0 = 16'h1F40;
    localparam logic [15:0] CIS_OVP_RELEASE = 16'h1770;
    localparam logic [15:0] CIS_UVLO = 16'h0DAC;
    localparam logic [15:0] CIS_UVLO_HYST = 16'h01F4;
    localparam logic [15:0] CIS_RAIL_SAG = 16'h00C8;
    localparam logic [15:0] CIS_AC_THRESH = 16'h04B0;
    // ==========================================================
    // Currents in mA, and divisors
    localparam logic [15:0] CIS_USB_ILIM_LO = 16'h0064;
    localparam logic [15:0] CIS_USB_ILIM_HI = 16'h01C2;
    localparam logic [15:0] CIS_AC_ILIM = 16'h07D0;
    localparam logic [15:0] CIS_USB_ICHG_LO = 16'h005A;
    localparam logic [15:0] CIS_USB_ICHG_HI = 16'h01C2;
    localparam logic [15:0] CIS_USB_IPRE = 16'h002D;
    localparam logic [15:0] CIS_AC_LOW_DIV = 16'h0005;
    localparam logic [15:0] CIS_PRE_DIV = 16'h000A;
    // ==========================================================
    // Power source encoding
    localparam logic [1:0] CIS_SRC_INPUT = 2'h1;
    localparam logic [1:0] CIS_SRC_BATT = 2'h2;
    localparam logic [1:0] CIS_SRC_BOTH = 2'h3;
endpackage

// ### rtl/cis_top.sv
// Charger input supervisor: qualification, limits, events
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module cis_top (
    // Clock, 10 MHz
    input wire logic ref_clk,
    // Asynchronous reset, active low
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Charger input level, mV
    input wire logic [15:0] charger_input,
    // System rail level, mV
    input wire logic [15:0] system_rail,
    // AC select pin level, mV
    input wire logic [15:0] ac_mode_sel_pin,
    // Charge level pin, logic
    input wire logic charge_level_pin,
    // Resistor programmed charge current, mA
    input wire logic [15:0] charge_current_set_pin,
    // Load exceeds what the input can give
    input wire logic load_over_limit,
    // Charger allowed to run
    output logic charge_enable,
    // Input current limit, mA
    output logic [15:0] input_current_limit,
    // Fast charge current, mA
    output logic [15:0] charge_current,
    // Precondition current, mA
    output logic [15:0] precond_current,
    // System power source
    output logic [1:0] power_source,
    // Rail sag is pulling charge current back
    output logic dynamic_current_ctrl,
    // Shared interrupt, active low
    output logic irq_out_n
);

    // ==========================================================
    // State record
    typedef struct packed {
        logic [1:0] ovp_threshold_sel; // Over-voltage pick
        logic input_irq_en;            // Input interrupt master
        logic connect_event_en;        // Connect enable
        logic disconnect_event_en;     // Disconnect enable
        logic [2:0] mask;              // Interrupt mask
        logic [15:0] rail_ref;         // Rail reference, mV
        logic ovp_trip;                // Over-voltage latched
        logic uv_lock;                 // Under-voltage latched
        logic valid_q;                 // Last input valid
        logic [2:0] events;            // Sticky event bits
        logic [31:0] rdata;            // Read data
        logic ac_mode;                 // AC mode decoded
        logic chg_en;                  // Charge allowed
        logic [15:0] ilim;             // Input limit
        logic [15:0] ichg;             // Charge current
        logic [15:0] ipre;             // Precondition current
        logic [1:0] src;               // Power source
        logic fold_back;               // Sag fold-back
    } cis_state_t;

    cis_state_t state;      // Registered state
    cis_state_t next_state; // Next state

    // Working terms of the combinational process
    logic [15:0] ovp_level;   // Selected trip point
    logic input_valid_status; // Qualified input
    logic ac_pin_level_status;// AC pin decode
    logic [15:0] base_ichg;   // Current before fold-back
    logic [2:0] ev_set;       // Events raised this cycle
    logic rail_sag;           // Rail more than 200mV below reference

    // ==========================================================
    // Next state logic
    always_comb begin
        next_state = state;
        ev_set = 3'h0;

        // Over-voltage threshold from the select field
        unique case (state.ovp_threshold_sel)
            2'h0: ovp_level = cis_pkg::CIS_OVP_6V6;
            2'h1: ovp_level = cis_pkg::CIS_OVP_7V0;
            2'h2: ovp_level = cis_pkg::CIS_OVP_7V5;
            2'h3: ovp_level = cis_pkg::CIS_OVP_8V0;
        endcase

        // Over-voltage trips above the pick; release is fixed
        // at 6.0V so a high pick gives a wider window
        if (charger_input > ovp_level) begin
            next_state.ovp_trip = 1'b1;
        end else if (charger_input < cis_pkg::CIS_OVP_RELEASE) begin
            next_state.ovp_trip = 1'b0;
        end

        // Under-voltage lock with 500mV of hysteresis
        if (charger_input < cis_pkg::CIS_UVLO) begin
            next_state.uv_lock = 1'b1;
        end else if (charger_input >= 16'(cis_pkg::CIS_UVLO
                     + cis_pkg::CIS_UVLO_HYST)) begin
            next_state.uv_lock = 1'b0;
        end

        // Valid only with neither lock held
        input_valid_status = !next_state.ovp_trip
                             && !next_state.uv_lock;
        next_state.valid_q = input_valid_status;
        next_state.chg_en = input_valid_status;

        // AC mode from the 1.2V decode of the select pin
        ac_pin_level_status = ac_mode_sel_pin
                              > cis_pkg::CIS_AC_THRESH;
        next_state.ac_mode = ac_pin_level_status;

        // Input current limit
        if (ac_pin_level_status) begin
            next_state.ilim = cis_pkg::CIS_AC_ILIM;
        end else if (charge_level_pin) begin
            next_state.ilim = cis_pkg::CIS_USB_ILIM_HI;
        end else begin
            next_state.ilim = cis_pkg::CIS_USB_ILIM_LO;
        end

        // Charge and precondition currents
        if (ac_pin_level_status) begin
            if (charge_level_pin) begin
                base_ichg = charge_current_set_pin;
            end else begin
                base_ichg = charge_current_set_pin
                            / cis_pkg::CIS_AC_LOW_DIV;
            end
            // Precondition follows the programmed figure, not
            // the level-pin cut, so both AC rows share it
            next_state.ipre = charge_current_set_pin
                              / cis_pkg::CIS_PRE_DIV;
        end else begin
            if (charge_level_pin) begin
                base_ichg = cis_pkg::CIS_USB_ICHG_HI;
            end else begin
                base_ichg = cis_pkg::CIS_USB_ICHG_LO;
            end
            next_state.ipre = cis_pkg::CIS_USB_IPRE;
        end

        // Fold-back halves the charge current while the rail
        // sits more than 200mV under its reference; a coarse
        // step, but it settles without a control loop
        rail_sag = ({1'b0, system_rail}
                    + {1'b0, cis_pkg::CIS_RAIL_SAG})
                   < {1'b0, state.rail_ref};
        next_state.fold_back = rail_sag;
        if (rail_sag) begin
            next_state.ichg = base_ichg >> 1;
        end else begin
            next_state.ichg = base_ichg;
        end

        // Power source choice
        if (!input_valid_status) begin
            next_state.src = cis_pkg::CIS_SRC_BATT;
        end else if (load_over_limit) begin
            next_state.src = cis_pkg::CIS_SRC_BOTH;
        end else begin
            next_state.src = cis_pkg::CIS_SRC_INPUT;
        end

        // Connect and disconnect are edges of input valid
        if (state.input_irq_en) begin
            if (input_valid_status && !state.valid_q
                && state.connect_event_en) begin
                ev_set[cis_pkg::CIS_EV_CON] = 1'b1;
                ev_set[cis_pkg::CIS_EV_FLAG] = 1'b1;
            end
            if (!input_valid_status && state.valid_q
                && state.disconnect_event_en) begin
                ev_set[cis_pkg::CIS_EV_DIS] = 1'b1;
                ev_set[cis_pkg::CIS_EV_FLAG] = 1'b1;
            end
        end

        // Read of the event word clears it; a new event in
        // the same cycle survives so none is lost
        if (reg_rd && reg_addr == cis_pkg::CIS_ADDR_EVENT) begin
            next_state.events = ev_set;
        end else begin
            next_state.events = state.events | ev_set;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                cis_pkg::CIS_ADDR_CTRL: begin
                    next_state.ovp_threshold_sel =
                        reg_wdata[cis_pkg::CIS_CTRL_OVP_LSB +: 2];
                    next_state.input_irq_en =
                        reg_wdata[cis_pkg::CIS_CTRL_IRQ_EN];
                    next_state.connect_event_en =
                        reg_wdata[cis_pkg::CIS_CTRL_CON_EN];
                    next_state.disconnect_event_en =
                        reg_wdata[cis_pkg::CIS_CTRL_DIS_EN];
                end
                cis_pkg::CIS_ADDR_MASK: begin
                    next_state.mask = reg_wdata[2:0];
                end
                cis_pkg::CIS_ADDR_RAIL_REF: begin
                    next_state.rail_ref = reg_wdata[15:0];
                end
                // Status and event words ignore writes
                default: begin
                end
            endcase
        end

        // Read data, valid in the next cycle only
        next_state.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                cis_pkg::CIS_ADDR_CTRL: begin
                    next_state.rdata[4:0] = {
                        state.disconnect_event_en,
                        state.connect_event_en,
                        state.input_irq_en,
                        state.ovp_threshold_sel};
                end
                cis_pkg::CIS_ADDR_STATUS: begin
                    next_state.rdata[cis_pkg::CIS_ST_VALID] =
                        state.valid_q;
                    next_state.rdata[cis_pkg::CIS_ST_AC] =
                        state.ac_mode;
                    next_state.rdata[cis_pkg::CIS_ST_OVP] =
                        state.ovp_trip;
                    next_state.rdata[cis_pkg::CIS_ST_UVLO] =
                        state.uv_lock;
                    next_state.rdata[cis_pkg::CIS_ST_FOLD] =
                        state.fold_back;
                end
                cis_pkg::CIS_ADDR_EVENT: begin
                    next_state.rdata[2:0] = state.events;
                end
                cis_pkg::CIS_ADDR_MASK: begin
                    next_state.rdata[2:0] = state.mask;
                end
                cis_pkg::CIS_ADDR_RAIL_REF: begin
                    next_state.rdata[15:0] = state.rail_ref;
                end
                // Unmapped addresses read as zero
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Start locked out until the input is seen good
            state <= '{
                ovp_threshold_sel: cis_pkg::CIS_CTRL_RST[1:0],
                input_irq_en: cis_pkg::CIS_CTRL_RST[2],
                connect_event_en: cis_pkg::CIS_CTRL_RST[3],
                disconnect_event_en: cis_pkg::CIS_CTRL_RST[4],
                mask: cis_pkg::CIS_MASK_RST,
                rail_ref: cis_pkg::CIS_RAIL_REF_RST,
                ovp_trip: 1'b0,
                uv_lock: 1'b1,
                valid_q: 1'b0,
                events: 3'h0,
                rdata: 32'h0000_0000,
                ac_mode: 1'b0,
                chg_en: 1'b0,
                ilim: cis_pkg::CIS_USB_ILIM_LO,
                ichg: 16'h0000,
                ipre: 16'h0000,
                src: cis_pkg::CIS_SRC_BATT,
                fold_back: 1'b0
            };
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = state.rdata;
    assign charge_enable = state.chg_en;
    assign input_current_limit = state.ilim;
    assign charge_current = state.ichg;
    assign precond_current = state.ipre;
    assign power_source = state.src;
    assign dynamic_current_ctrl = state.fold_back;
    // Low while any unmasked sticky event stands; it lifts
    // once the event word is read or the mask bits are cleared
    assign irq_out_n = ~|(state.events & state.mask);

endmodule

// ### verif/cis_assertions.sv
// Port-level checks for the charger input supervisor
`timescale 1ns/1ps

module cis_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] charger_input,
    input wire logic [15:0] system_rail,
    input wire logic [15:0] ac_mode_sel_pin,
    input wire logic charge_level_pin,
    input wire logic [15:0] charge_current_set_pin,
    input wire logic load_over_limit,
    input wire logic charge_enable,
    input wire logic [15:0] input_current_limit,
    input wire logic [15:0] charge_current,
    input wire logic [15:0] precond_current,
    input wire logic [1:0] power_source,
    input wire logic dynamic_current_ctrl,
    input wire logic irq_out_n
);
    // ==========================================================
    // Every check runs on the one clock, quiet in reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Qualification; 8.0V is the top trip, so it always stops charging
    chk_ovp_top_trip: assert property (
        charger_input > 16'h1F40 |=> !charge_enable)
        else $error("charging allowed above top over-voltage level");
    chk_ovp_no_resume: assert property (
        (charger_input > 16'h1F40) ##1 (charger_input >= 16'h1770)
        |=> !charge_enable)
        else $error("charging resumed at or above release level");
    chk_uvlo_off: assert property (
        charger_input < 16'h0DAC |=> !charge_enable)
        else $error("charging allowed below under-voltage level");
    // ==========================================================
    // Limits from the mode pins; fold-back excuses the charge figure
    chk_ac_in_limit: assert property (
        ac_mode_sel_pin > 16'h04B0 |=> input_current_limit == 16'h07D0)
        else $error("AC mode input limit wrong");
    chk_usb_in_limit: assert property (
        ac_mode_sel_pin <= 16'h04B0 |=> input_current_limit ==
        ($past(charge_level_pin) ? 16'h01C2 : 16'h0064))
        else $error("USB mode input limit wrong");
    chk_usb_charge_set: assert property (
        ac_mode_sel_pin <= 16'h04B0 |=> !charge_enable ||
        (precond_current == 16'h002D && (dynamic_current_ctrl ||
        charge_current == ($past(charge_level_pin) ? 16'h01C2 : 16'h005A))))
        else $error("USB mode charge currents wrong");
    chk_ac_low_div: assert property (
        ac_mode_sel_pin > 16'h04B0 && !charge_level_pin |=> !charge_enable
        || dynamic_current_ctrl
        || charge_current == $past(charge_current_set_pin) / 16'h0005)
        else $error("AC low level current not one fifth");
    chk_ac_precond: assert property (
        ac_mode_sel_pin > 16'h04B0 |=> precond_current ==
        $past(charge_current_set_pin) / 16'h000A)
        else $error("AC mode precondition not one tenth");
    // ==========================================================
    // Source, interrupt hold and idle read data
    chk_source_pick: assert property (
        charge_enable |-> power_source ==
        ($past(load_over_limit) ? 2'h3 : 2'h1))
        else $error("power source wrong while charging");
    chk_irq_holds: assert property (
        !irq_out_n && !reg_rd && !reg_wr |=> !irq_out_n)
        else $error("interrupt released without a read");
    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside read reply");
    // Main scenarios reached
    cov_irq_low: cover property (!irq_out_n);
    cov_fold_back: cover property (dynamic_current_ctrl);
    cov_both_src: cover property (power_source == 2'h3);
endmodule

// ### verif/cis_host.sv
// Host model: master of the supervisor's register port
`timescale 1ns/1ps

module cis_host (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    // ==========================================================
    // Bus idle from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; the slave never stalls us
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the charger input supervisor
`timescale 1ns/1ps

bind cis_top cis_assertions chk_u (.*);

module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic reg_wr, reg_rd, charge_enable, dynamic_current_ctrl, irq_out_n;
    logic [15:0] charger_input = 16'h0BB8;
    logic [15:0] system_rail = 16'h1388;
    logic [15:0] ac_mode_sel_pin = 16'h0000;
    logic charge_level_pin = 1'b0;
    logic load_over_limit = 1'b0;
    // Odd setting so the divide-by-5 and -10 truncate
    logic [15:0] charge_current_set_pin = 16'h03EB;
    logic [15:0] input_current_limit, charge_current, precond_current;
    logic [15:0] e_lim, e_chg, e_pre, ovp_tbl [4];
    logic [1:0] power_source;
    int n_errors = 0;
    int checks_done = 0;
    // 100 ns clock
    always #50 ref_clk = ~ref_clk;
    cis_top dut_u (.*);
    cis_host host_u (.*);
    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Outputs land one edge after the inputs are taken
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic vin(input logic [15:0] v);
        @(posedge ref_clk) charger_input <= v;
        step();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host_u.rd(a, rd_val);
        chk(rd_val, exp);
    endtask
    task automatic final_report();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the roughly 120 cycles the run needs
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end
    // ==========================================================
    // Main sequence
    initial begin
        ovp_tbl = '{cis_pkg::CIS_OVP_6V6, cis_pkg::CIS_OVP_7V0,
            cis_pkg::CIS_OVP_7V5, cis_pkg::CIS_OVP_8V0};
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        step();
        chk(32'(charge_enable), 32'h0);
        chk(32'(power_source), 32'(cis_pkg::CIS_SRC_BATT));
        rdc(cis_pkg::CIS_ADDR_CTRL, 32'h0000_0000);
        rdc(cis_pkg::CIS_ADDR_MASK, 32'h0000_0007);
        rdc(cis_pkg::CIS_ADDR_RAIL_REF, 32'h0000_1130);
        rdc(8'h14, 32'h0000_0000);
        // Connect with both enables set; read clears the flag
        host_u.wr(cis_pkg::CIS_ADDR_CTRL, 32'h0000_001C);
        vin(16'h1388);
        chk(32'(charge_enable), 32'h1);
        chk(32'(power_source), 32'(cis_pkg::CIS_SRC_INPUT));
        chk(32'(irq_out_n), 32'h0);
        rdc(cis_pkg::CIS_ADDR_EVENT, 32'h0000_0003);
        chk(32'(irq_out_n), 32'h1);
        rdc(cis_pkg::CIS_ADDR_EVENT, 32'h0000_0000);
        // Every mode pin pair; 1200 mV exactly still reads as USB
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            ac_mode_sel_pin <= m[1] ? 16'h07D0 : 16'h04B0;
            charge_level_pin <= m[0];
            step();
            if (m[1]) begin
                e_lim = cis_pkg::CIS_AC_ILIM;
                e_chg = m[0] ? 16'h03EB : 16'h00C8;
                e_pre = 16'h0064;
            end else begin
                e_lim = m[0] ? 16'h01C2 : 16'h0064;
                e_chg = m[0] ? 16'h01C2 : 16'h005A;
                e_pre = cis_pkg::CIS_USB_IPRE;
            end
            chk(32'(input_current_limit), 32'(e_lim));
            chk(32'(charge_current), 32'(e_chg));
            chk(32'(precond_current), 32'(e_pre));
            rdc(cis_pkg::CIS_ADDR_STATUS, {30'h0, m[1], 1'b1});
        end
        // Heavy load draws from both
        @(posedge ref_clk) load_over_limit <= 1'b1;
        step();
        chk(32'(power_source), 32'(cis_pkg::CIS_SRC_BOTH));
        // Rail sag fold-back at its exact edge, USB high level
        @(posedge ref_clk);
        load_over_limit <= 1'b0;
        ac_mode_sel_pin <= 16'h0000;
        system_rail <= 16'h1068;
        step();
        chk(32'(dynamic_current_ctrl), 32'h0);
        @(posedge ref_clk) system_rail <= 16'h1067;
        step();
        chk(32'(dynamic_current_ctrl), 32'h1);
        chk(32'(charge_current), 32'h0000_00E1);
        @(posedge ref_clk) system_rail <= 16'h1388;
        // Each over-voltage pick, then release only below 6.0V
        for (int s = 0; s < 4; s++) begin
            host_u.wr(cis_pkg::CIS_ADDR_CTRL, 32'h0000_001C | s);
            vin(ovp_tbl[s]);
            chk(32'(charge_enable), 32'h1);
            vin(ovp_tbl[s] + 16'h0001);
            chk(32'(charge_enable), 32'h0);
            vin(16'h1770);
            chk(32'(charge_enable), 32'h0);
            vin(16'h176F);
            chk(32'(charge_enable), 32'h1);
        end
        // Under-voltage and its 500 mV restart margin
        vin(16'h0DAB);
        chk(32'(charge_enable), 32'h0);
        vin(16'h0F9F);
        chk(32'(charge_enable), 32'h0);
        vin(16'h0FA0);
        chk(32'(charge_enable), 32'h1);
        rdc(cis_pkg::CIS_ADDR_EVENT, 32'h0000_0007);
        // Enables off: no event at all
        host_u.wr(cis_pkg::CIS_ADDR_CTRL, 32'h0000_0000);
        vin(16'h0BB8);
        vin(16'h1388);
        rdc(cis_pkg::CIS_ADDR_EVENT, 32'h0000_0000);
        // Masked: event still recorded, pin stays quiet
        host_u.wr(cis_pkg::CIS_ADDR_MASK, 32'h0000_0000);
        host_u.wr(cis_pkg::CIS_ADDR_CTRL, 32'h0000_001C);
        vin(16'h0BB8);
        chk(32'(irq_out_n), 32'h1);
        rdc(cis_pkg::CIS_ADDR_EVENT, 32'h0000_0005);
        final_report();
    end
endmodule
